//--- dv/ast_remote.sv
`timescale 1ns/1ps
module ast_remote #(
  parameter int bit_ns = 320
) (
  input  wire logic line,
  input  wire logic nine,
  output logic      rx_line
);
  logic [8:0] got [$];
  initial rx_line = 1'b1;
  always begin : listen
    logic [8:0] v;
    @(negedge line);
    #(bit_ns / 2);
    if (line === 1'b0) begin
      v = '0;
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        #(bit_ns);
        v[i] = line;
      end
      #(bit_ns);
      if (line === 1'b1)
        got.push_back(v);
    end
  end
  task automatic send(input logic [8:0] v, input logic stop);
    rx_line = 1'b0;
    #(bit_ns);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      rx_line = v[i];
      #(bit_ns);
    end
    rx_line = stop;
    #(bit_ns);
    rx_line = 1'b1;
    #(bit_ns);
  endtask : send
  task automatic blip;
    rx_line = 1'b0;
    #(bit_ns / 4);
    rx_line = 1'b1;
    #(bit_ns);
  endtask : blip
endmodule : ast_remote

//--- dv/ast_uart_chk_sva.sv
`timescale 1ns/1ps
module ast_uart_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serial_port_enable,
  input wire logic tx_enable,
  input wire logic continuous_receive_enable,
  input wire logic clocked_mode_select,
  input wire logic transmit_polarity_invert,
  input wire logic transmit_irq_enable,
  input wire logic receive_irq_enable,
  input wire logic holding_write,
  input wire logic transmit_pin,
  input wire logic transmit_pin_oe,
  input wire logic transmit_buffer_empty_flag,
  input wire logic transmit_irq,
  input wire logic transmit_shift_empty,
  input wire logic receive_data_flag,
  input wire logic receive_irq,
  input wire logic overrun_error
);
  wire logic tx_on = tx_enable && serial_port_enable && !clocked_mode_select;
  wire logic empty = transmit_buffer_empty_flag;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_idle_mark: assert property (
    transmit_shift_empty [*2] |-> transmit_pin == !transmit_polarity_invert)
    else $error("idle line not at mark");
  a_oe_port: assert property (
    $rose(serial_port_enable) |-> ##[0:1] transmit_pin_oe)
    else $error("pin not driven with port on");
  a_txirq_gate: assert property (
    transmit_irq == (empty && transmit_irq_enable))
    else $error("tx request not gated by enable");
  a_rxirq_gate: assert property (
    receive_irq == (receive_data_flag && receive_irq_enable))
    else $error("rx request not gated by enable");
  a_flag_enable: assert property (
    $rose(tx_enable) && serial_port_enable && !clocked_mode_select
    |-> ##[1:2] empty) else $error("flag not set on enable");
  a_flag_busy: assert property (
    (tx_on && !empty) [*3]
    |-> !transmit_shift_empty || !$past(transmit_shift_empty))
    else $error("flag clear with shifter idle");
  a_flag_valid: assert property (
    holding_write && tx_on && empty && !transmit_shift_empty
    |-> ##2 (!empty || $past(transmit_shift_empty)))
    else $error("flag not clear after queued write");
  a_rx_off: assert property (
    !continuous_receive_enable [*2] |-> !receive_data_flag && !overrun_error)
    else $error("receiver active while disabled");
  a_tx_gated: assert property (
    holding_write && !tx_enable && transmit_shift_empty |=>
    transmit_shift_empty [*4]) else $error("send while disabled");
  c_queued: cover property ($fell(empty));
  c_overrun: cover property ($rose(overrun_error));
  c_rx_data: cover property ($rose(receive_data_flag));
endmodule : ast_uart_chk

bind ast_uart ast_uart_chk ast_uart_chk_i (
  .core_clk                   (core_clk),
  .nrst                       (nrst),
  .serial_port_enable         (serial_port_enable),
  .tx_enable                  (tx_enable),
  .continuous_receive_enable  (continuous_receive_enable),
  .clocked_mode_select        (clocked_mode_select),
  .transmit_polarity_invert   (transmit_polarity_invert),
  .transmit_irq_enable        (transmit_irq_enable),
  .receive_irq_enable         (receive_irq_enable),
  .holding_write              (holding_write),
  .transmit_pin               (transmit_pin),
  .transmit_pin_oe            (transmit_pin_oe),
  .transmit_buffer_empty_flag (transmit_buffer_empty_flag),
  .transmit_irq               (transmit_irq),
  .transmit_shift_empty       (transmit_shift_empty),
  .receive_data_flag          (receive_data_flag),
  .receive_irq                (receive_irq),
  .overrun_error              (overrun_error)
);

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  import ast_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, serial_port_enable = 1'b0;
  logic tx_enable = 1'b0, continuous_receive_enable = 1'b0;
  logic clocked_mode_select = 1'b0, transmit_polarity_invert = 1'b0;
  logic nine_bit_mode = 1'b0, wide_divider = 1'b1;
  logic [15:0] rate_divisor = 16'h0001;
  logic transmit_irq_enable = 1'b0, receive_irq_enable = 1'b0;
  logic holding_write = 1'b0, read_strobe = 1'b0, overrun_clear = 1'b0;
  ast_char_s holding_data = '0;
  logic receive_pin, transmit_pin, transmit_pin_oe, transmit_irq;
  logic transmit_buffer_empty_flag, transmit_shift_empty;
  logic receive_data_flag, receive_irq, overrun_error;
  ast_rx_word_s receive_read_port;
  integer seed = 32'h999296E1;
  int mismatches = 0, comparisons = 0, cycles = 0;

  ast_uart ast_uart_i (
    .core_clk                   (core_clk),
    .nrst                       (nrst),
    .serial_port_enable         (serial_port_enable),
    .tx_enable                  (tx_enable),
    .continuous_receive_enable  (continuous_receive_enable),
    .clocked_mode_select        (clocked_mode_select),
    .transmit_polarity_invert   (transmit_polarity_invert),
    .nine_bit_mode              (nine_bit_mode),
    .wide_divider               (wide_divider),
    .rate_divisor               (rate_divisor),
    .transmit_irq_enable        (transmit_irq_enable),
    .receive_irq_enable         (receive_irq_enable),
    .holding_write              (holding_write),
    .holding_data               (holding_data),
    .read_strobe                (read_strobe),
    .overrun_clear              (overrun_clear),
    .receive_pin                (receive_pin),
    .transmit_pin               (transmit_pin),
    .transmit_pin_oe            (transmit_pin_oe),
    .transmit_buffer_empty_flag (transmit_buffer_empty_flag),
    .transmit_irq               (transmit_irq),
    .transmit_shift_empty       (transmit_shift_empty),
    .receive_read_port          (receive_read_port),
    .receive_data_flag          (receive_data_flag),
    .receive_irq                (receive_irq),
    .overrun_error              (overrun_error)
  );
  ast_remote #(.bit_ns(320)) ast_remote_i (
    .line    (transmit_pin),
    .nine    (nine_bit_mode),
    .rx_line (receive_pin)
  );

  always #5 core_clk = ~core_clk;

  function automatic logic [8:0] fmt(input logic [8:0] v, input logic n);
    return n ? v : {1'b0, v[7:0]};
  endfunction : fmt

  function automatic logic [9:0] word(input logic [8:0] v, input logic fe);
    return {v, fe};
  endfunction : word

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic put(input logic [8:0] v);
    holding_data = v;
    holding_write = 1'b1;
    tick(1);
    holding_write = 1'b0;
  endtask : put

  task automatic pop(input logic [9:0] exp);
    check(receive_data_flag, 1'b1);
    check(receive_read_port, exp);
    check(receive_irq, receive_irq_enable);
    read_strobe = 1'b1;
    tick(1);
    read_strobe = 1'b0;
    tick(2);
  endtask : pop

  task automatic wait_got(input int n);
    for (int i = 0; i < 3000 && ast_remote_i.got.size() < n; i++)
      tick(1);
  endtask : wait_got

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin : main
    logic [8:0] v [4];
    tick(12);
    nrst = 1'b1;
    tick(2);
    check(transmit_pin, ast_mark);
    serial_port_enable = 1'b1;
    put(9'h0A5);
    tick(400);
    check(10'(ast_remote_i.got.size()), 10'h000);
    check(transmit_pin_oe, 1'b1);
    tx_enable = 1'b1;
    tick(2);
    check(transmit_buffer_empty_flag, 1'b1);
    for (int m = 0; m < 4; m++) begin
      nine_bit_mode = m[0];
      wide_divider = m[1];
      rate_divisor = m[1] ? 16'h0001 : 16'h0301;
      transmit_irq_enable = m[0];
      v[0] = 9'($random(seed));
      v[1] = (m == 3) ? 9'h1FF : 9'($random(seed));
      put(v[0]);
      tick(3);
      check(transmit_irq, m[0]);
      put(v[1]);
      transmit_irq_enable = 1'b0;
      tick(2);
      check(transmit_buffer_empty_flag, 1'b0);
      check(transmit_shift_empty, 1'b0);
      wait_got(2);
      check(10'(ast_remote_i.got.size()), 10'h002);
      check(ast_remote_i.got[0], fmt(v[0], m[0]));
      check(ast_remote_i.got[1], fmt(v[1], m[0]));
      ast_remote_i.got.delete();
      tick(20);
      check(transmit_buffer_empty_flag, 1'b1);
    end
    nine_bit_mode = 1'b1;
    receive_irq_enable = 1'b1;
    ast_remote_i.send(9'h155, 1'b1);
    tick(2);
    check(receive_data_flag, 1'b0);
    continuous_receive_enable = 1'b1;
    tick(2);
    ast_remote_i.blip();
    for (int i = 0; i < 4; i++)
      v[i] = 9'($random(seed));
    ast_remote_i.send(v[0], 1'b1);
    ast_remote_i.send(v[1], 1'b0);
    tick(2);
    pop(word(v[0], 1'b0));
    pop(word(v[1], 1'b1));
    check(receive_data_flag, 1'b0);
    for (int i = 0; i < 3; i++)
      ast_remote_i.send(v[i], 1'b1);
    tick(2);
    check(overrun_error, 1'b1);
    pop(word(v[0], 1'b0));
    pop(word(v[1], 1'b0));
    ast_remote_i.send(v[3], 1'b1);
    tick(2);
    check(receive_data_flag, 1'b0);
    overrun_clear = 1'b1;
    tick(1);
    overrun_clear = 1'b0;
    ast_remote_i.send(v[3], 1'b1);
    tick(2);
    check(overrun_error, 1'b0);
    pop(word(v[3], 1'b0));
    transmit_polarity_invert = 1'b1;
    tick(1);
    check(transmit_pin, 1'b0);
    stop_test();
  end
endmodule : tb

//--- src/ast_fifo.sv
`timescale 1ns/1ps
module ast_fifo #(
  parameter int width = 10,
  parameter int depth = 2
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clear,
  input  wire logic [width-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [width-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int aw = (depth > 1) ? $clog2(depth) : 1;
  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wptr;
  logic [aw-1:0]    rptr;
  logic [aw:0]      count;
  logic [aw-1:0]    next_wptr;
  logic [aw-1:0]    next_rptr;
  logic [aw:0]      next_count;
  logic             do_wr;
  logic             do_rd;

  always_comb begin
    in_ready   = (count != (aw+1)'(depth));
    out_valid  = (count != '0);
    out_data   = mem[rptr];
    do_wr      = in_valid && in_ready;
    do_rd      = out_valid && out_ready;
    next_wptr  = wptr;
    next_rptr  = rptr;
    next_count = count;
    if (clear) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
    end else begin
      if (do_wr) begin
        next_wptr = (wptr == aw'(depth - 1)) ? '0 : wptr + 1'b1;
      end
      if (do_rd) begin
        next_rptr = (rptr == aw'(depth - 1)) ? '0 : rptr + 1'b1;
      end
      next_count = count + (aw+1)'(do_wr) - (aw+1)'(do_rd);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_wr && !clear) begin
      mem[wptr] <= in_data;
    end
  end
endmodule : ast_fifo

//--- src/ast_pkg.sv
package ast_pkg;
  localparam int          ast_oversample     = 16;
  localparam logic [3:0]  ast_os_last        = 4'hF;
  localparam logic [3:0]  ast_os_half        = 4'h7;
  localparam logic [3:0]  ast_vote_a         = 4'h6;
  localparam logic [3:0]  ast_vote_b         = 4'h7;
  localparam logic [3:0]  ast_vote_c         = 4'h8;
  localparam logic [3:0]  ast_bits_eight     = 4'h8;
  localparam logic [3:0]  ast_bits_nine      = 4'h9;
  localparam logic [15:0] ast_baud_default   = 16'h001A;
  localparam int          ast_fifo_depth     = 2;
  localparam logic        ast_mark           = 1'b1;
  localparam logic        ast_space          = 1'b0;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ast_char_s;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       frame_err;
  } ast_rx_word_s;

  typedef enum logic [1:0] {
    ast_tx_idle  = 2'b00,
    ast_tx_start = 2'b01,
    ast_tx_data  = 2'b11,
    ast_tx_stop  = 2'b10
  } ast_tx_state_e;

  typedef enum logic [1:0] {
    ast_rx_idle  = 2'b00,
    ast_rx_start = 2'b01,
    ast_rx_data  = 2'b11,
    ast_rx_stop  = 2'b10
  } ast_rx_state_e;
endpackage : ast_pkg

//--- src/ast_uart.sv
`timescale 1ns/1ps
module ast_uart
  import ast_pkg::*;
#(
  parameter logic [15:0] baud_div = ast_baud_default
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             serial_port_enable,
  input  wire logic             tx_enable,
  input  wire logic             continuous_receive_enable,
  input  wire logic             clocked_mode_select,
  input  wire logic             transmit_polarity_invert,
  input  wire logic             nine_bit_mode,
  input  wire logic             wide_divider,
  input  wire logic [15:0]      rate_divisor,
  input  wire logic             transmit_irq_enable,
  input  wire logic             receive_irq_enable,
  input  wire logic             holding_write,
  input  wire ast_pkg::ast_char_s holding_data,
  input  wire logic             read_strobe,
  input  wire logic             overrun_clear,
  input  wire logic             receive_pin,
  output logic                  transmit_pin,
  output logic                  transmit_pin_oe,
  output logic                  transmit_buffer_empty_flag,
  output logic                  transmit_irq,
  output logic                  transmit_shift_empty,
  output ast_pkg::ast_rx_word_s receive_read_port,
  output logic                  receive_data_flag,
  output logic                  receive_irq,
  output logic                  overrun_error
);
  import ast_pkg::*;

  logic          tx_on;
  logic          rx_on;
  logic [15:0]   div_cnt;
  logic [15:0]   next_div_cnt;
  logic          tick;
  logic          rx_s1;
  logic          rx_s2;
  // Transmit state
  ast_tx_state_e tx_st;
  ast_tx_state_e next_tx_st;
  logic [3:0]    tx_os;
  logic [3:0]    next_tx_os;
  logic [3:0]    tx_bit;
  logic [3:0]    next_tx_bit;
  logic [8:0]    transmit_shift_reg;
  logic [8:0]    next_tsr;
  logic          tx_line;
  logic          next_tx_line;
  ast_char_s     hold;
  ast_char_s     next_hold;
  logic          hold_full;
  logic          next_hold_full;
  logic          empty_q;
  logic          next_empty_q;
  // Receive state
  ast_rx_state_e rx_st;
  ast_rx_state_e next_rx_st;
  logic [3:0]    rx_os;
  logic [3:0]    next_rx_os;
  logic [3:0]    rx_bit;
  logic [3:0]    next_rx_bit;
  logic [8:0]    receive_shift_reg;
  logic [8:0]    next_rsr;
  logic [2:0]    votes;
  logic [2:0]    next_votes;
  logic          rx_prev;
  logic          ovr;
  logic          next_ovr;
  logic          push;
  ast_rx_word_s  push_word;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  ast_rx_word_s  fifo_out;
  logic          maj;
  logic [3:0]    nbits;

  assign tx_on = tx_enable && serial_port_enable && !clocked_mode_select;
  assign rx_on = continuous_receive_enable && serial_port_enable
                 && !clocked_mode_select;
  assign nbits = nine_bit_mode ? ast_bits_nine : ast_bits_eight;

  // Sixteen-times baud tick from an 8- or 16-bit divider
  always_comb begin
    tick = (div_cnt == 16'h0000);
    if (tick) begin
      next_div_cnt = wide_divider ? rate_divisor
                                  : {8'h00, rate_divisor[7:0]};
    end else begin
      next_div_cnt = div_cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= baud_div;
      rx_s1   <= ast_mark;
      rx_s2   <= ast_mark;
      rx_prev <= ast_mark;
    end else begin
      div_cnt <= next_div_cnt;
      rx_s1   <= receive_pin;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  // Transmitter
  always_comb begin
    next_tx_st     = tx_st;
    next_tx_os     = tx_os;
    next_tx_bit    = tx_bit;
    next_tsr       = transmit_shift_reg;
    next_tx_line   = tx_line;
    next_hold      = hold;
    next_hold_full = hold_full;
    if (holding_write) begin
      next_hold      = holding_data;
      next_hold_full = 1'b1;
    end
    if (!tx_on) begin
      next_tx_st     = ast_tx_idle;
      next_tx_line   = ast_mark;
      next_hold_full = 1'b0;
    end else begin
      case (tx_st)
        ast_tx_idle: begin
          next_tx_line = ast_mark;
          if (hold_full) begin
            next_tsr       = {hold.ninth, hold.data};
            next_hold_full = holding_write;
            next_tx_st     = ast_tx_start;
            next_tx_os     = '0;
            next_tx_line   = ast_space;
          end
        end
        ast_tx_start, ast_tx_data: begin
          if (tick) begin
            next_tx_os = tx_os + 4'h1;
            if (tx_os == ast_os_last) begin
              if (tx_st == ast_tx_start) begin
                next_tx_bit = '0;
                next_tx_st  = ast_tx_data;
              end else begin
                next_tx_bit = tx_bit + 4'h1;
                next_tsr    = {1'b0, transmit_shift_reg[8:1]};
              end
              if (tx_st == ast_tx_data && tx_bit == nbits - 4'h1) begin
                next_tx_st   = ast_tx_stop;
                next_tx_line = ast_mark;
              end else if (tx_st == ast_tx_start) begin
                next_tx_line = transmit_shift_reg[0];
              end else begin
                next_tx_line = transmit_shift_reg[1];
              end
            end
          end
        end
        ast_tx_stop: begin
          if (tick && tx_os == ast_os_last) begin
            next_tx_st = ast_tx_idle;
          end else if (tick) begin
            next_tx_os = tx_os + 4'h1;
          end
        end
        default: next_tx_st = ast_tx_idle;
      endcase
    end
    // Flag is registered from next_hold_full, so it changes on the same edge as hold_full
    next_empty_q = tx_on && !next_hold_full;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_st     <= ast_tx_idle;
      tx_os     <= '0;
      tx_bit    <= '0;
      transmit_shift_reg       <= '0;
      tx_line   <= ast_mark;
      hold      <= '0;
      hold_full <= 1'b0;
      empty_q   <= 1'b0;
    end else begin
      tx_st     <= next_tx_st;
      tx_os     <= next_tx_os;
      tx_bit    <= next_tx_bit;
      transmit_shift_reg       <= next_tsr;
      tx_line   <= next_tx_line;
      hold      <= next_hold;
      hold_full <= next_hold_full;
      empty_q   <= next_empty_q;
    end
  end

  assign transmit_pin    = tx_line ^ transmit_polarity_invert;
  assign transmit_pin_oe = serial_port_enable;
  assign transmit_buffer_empty_flag = empty_q;
  assign transmit_irq    = empty_q && transmit_irq_enable;
  assign transmit_shift_empty = (tx_st == ast_tx_idle);

  // Receiver
  assign maj = (votes[0] & votes[1]) | (votes[0] & votes[2])
               | (votes[1] & votes[2]);

  always_comb begin
    next_rx_st  = rx_st;
    next_rx_os  = rx_os;
    next_rx_bit = rx_bit;
    next_rsr    = receive_shift_reg;
    next_votes  = votes;
    next_ovr    = ovr;
    push        = 1'b0;
    push_word   = '0;
    if (overrun_clear) begin
      next_ovr = 1'b0;
    end
    if (!rx_on) begin
      next_rx_st = ast_rx_idle;
      next_ovr   = 1'b0;
    end else begin
      if (tick) begin
        next_rx_os = rx_os + 4'h1;
        if (rx_os == ast_vote_a) next_votes[0] = rx_s2;
        if (rx_os == ast_vote_b) next_votes[1] = rx_s2;
        if (rx_os == ast_vote_c) next_votes[2] = rx_s2;
      end
      case (rx_st)
        ast_rx_idle: begin
          if (rx_prev && !rx_s2 && !ovr) begin
            next_rx_st = ast_rx_start;
            next_rx_os = '0;
          end
        end
        ast_rx_start: begin
          if (tick && rx_os == ast_os_half) begin
            if (rx_s2 != ast_space) begin
              next_rx_st = ast_rx_idle;
            end
          end else if (tick && rx_os == ast_os_last) begin
            next_rx_st  = ast_rx_data;
            next_rx_bit = '0;
          end
        end
        ast_rx_data: begin
          if (tick && rx_os == ast_os_last) begin
            next_rsr    = nine_bit_mode ? {maj, receive_shift_reg[8:1]}
                                        : {1'b0, maj, receive_shift_reg[7:1]};
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == nbits - 4'h1) begin
              next_rx_st = ast_rx_stop;
            end
          end
        end
        ast_rx_stop: begin
          if (tick && rx_os == ast_vote_c) begin
            push_word.ninth     = receive_shift_reg[8];
            push_word.data      = receive_shift_reg[7:0];
            push_word.frame_err = (votes[0] & votes[1]) | (votes[0] & rx_s2)
                                  | (votes[1] & rx_s2) ? 1'b0 : 1'b1;
            next_rx_st = ast_rx_idle;
            if (fifo_in_ready) begin
              push = 1'b1;
            end else begin
              next_ovr = 1'b1;
            end
          end
        end
        default: next_rx_st = ast_rx_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_st  <= ast_rx_idle;
      rx_os  <= '0;
      rx_bit <= '0;
      receive_shift_reg    <= '0;
      votes  <= 3'h7;
      ovr    <= 1'b0;
    end else begin
      rx_st  <= next_rx_st;
      rx_os  <= next_rx_os;
      rx_bit <= next_rx_bit;
      receive_shift_reg    <= next_rsr;
      votes  <= next_votes;
      ovr    <= next_ovr;
    end
  end

  ast_fifo #(
    .width ($bits(ast_rx_word_s)),
    .depth (ast_fifo_depth)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .clear     (!rx_on),
    .in_data   (push_word),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (read_strobe)
  );

  assign receive_read_port = fifo_out;
  assign receive_data_flag = rx_on && fifo_out_valid;
  assign receive_irq       = receive_data_flag && receive_irq_enable;
  assign overrun_error     = ovr;
endmodule : ast_uart
